// File: src/phy_link_status.sv
`timescale 1ns/1ps
// Behaviour
// R1: protocol-select high puts the link interface into the beta protocol.
// R2: protocol-select low puts the link interface into the legacy protocol.
// R3: the system holds protocol-select fixed while running.
// R4: cable-inactive goes high when no port sees incoming bias.
// R5: cable-inactive goes low once any port sees incoming bias.
// R6: loss of cable power raises a maskable interrupt.
// R7: port 0 strap sampled after reset: 0 bilingual, 1 legacy-only.
// R8: port 1 strap sampled after reset: 0 bilingual, 1 legacy-only.
// R9: control and data lines are two-way; released lines are held outside.
// R10: a legacy-only port never emits beta signalling.
// R11: strap modes latch after reset and stay until next reset.
module phy_link_status (
  // clock and reset
  input  wire logic                                aclk,
  input  wire logic                                aresetn,
  // write address
  input  wire logic [phy_link_pkg::ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic [2:0]                          s_axi_awprot,
  input  wire logic                                s_axi_awvalid,
  output logic                                     s_axi_awready,
  // write data and response
  input  wire logic [phy_link_pkg::DATA_W-1:0]     s_axi_wdata,
  input  wire logic [phy_link_pkg::STRB_W-1:0]     s_axi_wstrb,
  input  wire logic                                s_axi_wvalid,
  output logic                                     s_axi_wready,
  output logic [1:0]                               s_axi_bresp,
  output logic                                     s_axi_bvalid,
  input  wire logic                                s_axi_bready,
  // read
  input  wire logic [phy_link_pkg::ADDR_W-1:0]     s_axi_araddr,
  input  wire logic [2:0]                          s_axi_arprot,
  input  wire logic                                s_axi_arvalid,
  output logic                                     s_axi_arready,
  output logic [phy_link_pkg::DATA_W-1:0]          s_axi_rdata,
  output logic [1:0]                               s_axi_rresp,
  output logic                                     s_axi_rvalid,
  input  wire logic                                s_axi_rready,
  // straps and sensing
  input  wire logic                                link_protocol_select,
  input  wire logic                                port0_legacy_only_strap,
  input  wire logic                                port1_legacy_only_strap,
  input  wire logic [phy_link_pkg::NUM_PORTS-1:0]  port_bias_detect,
  input  wire logic                                cable_power_sense,
  // link lines
  input  wire logic [phy_link_pkg::LINK_C_W-1:0]   link_control_lines_in,
  output logic [phy_link_pkg::LINK_C_W-1:0]        link_control_lines_out,
  output logic [phy_link_pkg::LINK_C_W-1:0]        link_control_lines_oe,
  input  wire logic [phy_link_pkg::LINK_D_W-1:0]   link_data_lines_in,
  output logic [phy_link_pkg::LINK_D_W-1:0]        link_data_lines_out,
  output logic [phy_link_pkg::LINK_D_W-1:0]        link_data_lines_oe,
  // status
  output logic                                     cable_inactive_flag,
  output logic                                     link_beta_mode,
  output logic [phy_link_pkg::NUM_STRAPS-1:0]      port_beta_tx_en,
  output logic                                     irq
);
  localparam int DW = phy_link_pkg::DATA_W;
  localparam int CW = phy_link_pkg::LINK_C_W;
  localparam int LW = phy_link_pkg::LINK_D_W;
  localparam int SN = phy_link_pkg::NUM_STRAPS;
  localparam int IW = phy_link_pkg::INT_W;
  strap_if strap_bus ();
  logic                                awready_reg, aw_held_reg, wready_reg, w_held_reg;
  logic [phy_link_pkg::ADDR_W-1:0]     awaddr_reg;
  logic [DW-1:0]                       wdata_reg, wmask, rd_data;
  logic [phy_link_pkg::STRB_W-1:0]     wstrb_reg;
  logic                                bvalid_reg, arready_reg, rvalid_reg, wr_commit, wr_hit;
  logic                                rd_hit;
  logic [1:0]                          bresp_reg, rresp_reg;
  logic [DW-1:0]                       rdata_reg;
  logic [phy_link_pkg::CTRL_W-1:0]     ctrl_reg;
  logic [IW-1:0]                       int_status_reg, int_mask_reg, int_events, int_clear;
  logic [CW+LW-1:0]                    link_out_reg;
  logic                                cna_reg, cna_next, cps_prev_reg, beta_reg, irq_reg;
  logic [SN-1:0]                       beta_tx_reg;
  logic [CW-1:0]                       ctl_out_reg, ctl_oe_reg;
  logic [LW-1:0]                       d_out_reg, d_oe_reg;
  logic                                drive_en;

  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------
  strap_capture u_strap (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .strap_in ({port1_legacy_only_strap, port0_legacy_only_strap}),
    .modes    (strap_bus.capture)
  );
  // ----------------------------------------------------------------
  // write channels
  // ----------------------------------------------------------------
  assign wr_commit = aw_held_reg && w_held_reg && !bvalid_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      aw_held_reg <= 1'b0;
      awaddr_reg  <= '0;
    end else if (s_axi_awvalid && awready_reg) begin
      awready_reg <= 1'b0;
      aw_held_reg <= 1'b1;
      awaddr_reg  <= s_axi_awaddr;
    end else if (wr_commit) begin
      aw_held_reg <= 1'b0;
    end else if (!aw_held_reg && !bvalid_reg) begin
      awready_reg <= 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_reg <= 1'b0;
      w_held_reg <= 1'b0;
      wdata_reg  <= phy_link_pkg::WORD_ZERO;
      wstrb_reg  <= '0;
    end else if (s_axi_wvalid && wready_reg) begin
      wready_reg <= 1'b0;
      w_held_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata;
      wstrb_reg  <= s_axi_wstrb;
    end else if (wr_commit) begin
      w_held_reg <= 1'b0;
    end else if (!w_held_reg && !bvalid_reg) begin
      wready_reg <= 1'b1;
    end
  end
  always_comb begin
    case (awaddr_reg)
      phy_link_pkg::CTRL_OFF,
      phy_link_pkg::STATUS_OFF,
      phy_link_pkg::INT_STATUS_OFF,
      phy_link_pkg::INT_MASK_OFF,
      phy_link_pkg::LINK_OUT_OFF,
      phy_link_pkg::LINK_IN_OFF: wr_hit = 1'b1;
      default:                   wr_hit = 1'b0;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= phy_link_pkg::RESP_OKAY;
    end else if (wr_commit) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? phy_link_pkg::RESP_OKAY : phy_link_pkg::RESP_SLVERR;
    end else if (s_axi_bready && bvalid_reg) begin
      bvalid_reg <= 1'b0;
    end
  end
  genvar gb;
  generate
    for (gb = 0; gb < phy_link_pkg::STRB_W; gb++) begin : g_lane
      assign wmask[gb*phy_link_pkg::BYTE_W +: phy_link_pkg::BYTE_W] =
        {phy_link_pkg::BYTE_W{wstrb_reg[gb]}};
    end
  endgenerate

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg     <= '0;
      int_mask_reg <= '0;
      link_out_reg <= '0;
    end else if (wr_commit) begin
      if (awaddr_reg == phy_link_pkg::CTRL_OFF) begin
        ctrl_reg <= (ctrl_reg & ~wmask[IW-1:0]) | (wdata_reg[IW-1:0] & wmask[IW-1:0]);
      end
      if (awaddr_reg == phy_link_pkg::INT_MASK_OFF) begin
        int_mask_reg <= (int_mask_reg & ~wmask[IW-1:0]) | (wdata_reg[IW-1:0] & wmask[IW-1:0]);
      end
      if (awaddr_reg == phy_link_pkg::LINK_OUT_OFF) begin
        link_out_reg <= (link_out_reg & ~wmask[CW+LW-1:0])
                      | (wdata_reg[CW+LW-1:0] & wmask[CW+LW-1:0]);
      end
    end
  end
  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  always_comb begin
    rd_data = phy_link_pkg::WORD_ZERO;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      phy_link_pkg::CTRL_OFF:       rd_data[phy_link_pkg::CTRL_W-1:0] = ctrl_reg;
      phy_link_pkg::STATUS_OFF: begin
        rd_data[phy_link_pkg::ST_CNA]  = cna_reg;
        rd_data[phy_link_pkg::ST_CPS]  = cps_prev_reg;
        rd_data[phy_link_pkg::ST_BETA] = beta_reg;
        rd_data[phy_link_pkg::ST_LEGACY_LSB +: SN] = strap_bus.legacy_only;
        rd_data[phy_link_pkg::ST_BIAS_LSB +: phy_link_pkg::NUM_PORTS] = port_bias_detect;
      end
      phy_link_pkg::INT_STATUS_OFF: rd_data[IW-1:0] = int_status_reg;
      phy_link_pkg::INT_MASK_OFF:   rd_data[IW-1:0] = int_mask_reg;
      phy_link_pkg::LINK_OUT_OFF:   rd_data[CW+LW-1:0] = link_out_reg;
      phy_link_pkg::LINK_IN_OFF:    rd_data[CW+LW-1:0] = {link_control_lines_in,
                                                          link_data_lines_in};
      default:                      rd_hit = 1'b0;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= phy_link_pkg::WORD_ZERO;
      rresp_reg   <= phy_link_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_data;
      rresp_reg   <= rd_hit ? phy_link_pkg::RESP_OKAY : phy_link_pkg::RESP_SLVERR;
    end else if (s_axi_rready && rvalid_reg) begin
      rvalid_reg <= 1'b0;
    end else if (!rvalid_reg) begin
      arready_reg <= 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // cable status and events
  // ----------------------------------------------------------------
  assign cna_next = ~|port_bias_detect;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cna_reg      <= 1'b1;
      cps_prev_reg <= 1'b0;
    end else begin
      cna_reg      <= cna_next; // [R4] [R5]
      cps_prev_reg <= cable_power_sense;
    end
  end
  always_comb begin
    int_events = '0;
    int_events[phy_link_pkg::INT_POWER_LOST] = cps_prev_reg && !cable_power_sense; // [R6]
    int_events[phy_link_pkg::INT_CABLE_DOWN] = cna_next && !cna_reg;
    int_events[phy_link_pkg::INT_CABLE_UP]   = !cna_next && cna_reg;
    int_clear = '0;
    if (wr_commit && awaddr_reg == phy_link_pkg::INT_STATUS_OFF) begin
      int_clear = wdata_reg[IW-1:0] & wmask[IW-1:0];
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_status_reg <= '0;
      irq_reg        <= 1'b0;
    end else begin
      int_status_reg <= (int_status_reg & ~int_clear) | int_events; // [R6]
      irq_reg        <= |(int_status_reg & int_mask_reg);
    end
  end
  // ----------------------------------------------------------------
  // link protocol and port modes
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      beta_reg <= 1'b0;
    end else begin
      beta_reg <= link_protocol_select; // [R1] [R2]
    end
  end
  genvar gp;
  generate
    for (gp = 0; gp < SN; gp++) begin : g_port
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          beta_tx_reg[gp] <= 1'b0;
        end else begin
          beta_tx_reg[gp] <= ctrl_reg[phy_link_pkg::CTRL_BETA_LSB + gp] && strap_bus.captured
                             && !strap_bus.legacy_only[gp]; // [R10]
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // link line drivers
  // ----------------------------------------------------------------
  assign drive_en = ctrl_reg[phy_link_pkg::CTRL_DRIVE] && strap_bus.captured;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_out_reg <= '0;
      ctl_oe_reg  <= '0;
      d_out_reg   <= '0;
      d_oe_reg    <= '0;
    end else begin
      ctl_out_reg <= link_out_reg[phy_link_pkg::LINK_CTL_LSB +: CW];
      d_out_reg   <= link_out_reg[LW-1:0];
      ctl_oe_reg  <= {CW{drive_en}}; // [R9]
      d_oe_reg    <= {LW{drive_en}}; // [R9]
    end
  end
  assign s_axi_awready          = awready_reg;
  assign s_axi_wready           = wready_reg;
  assign s_axi_bvalid           = bvalid_reg;
  assign s_axi_bresp            = bresp_reg;
  assign s_axi_arready          = arready_reg;
  assign s_axi_rvalid           = rvalid_reg;
  assign s_axi_rdata            = rdata_reg;
  assign s_axi_rresp            = rresp_reg;
  assign cable_inactive_flag    = cna_reg;
  assign link_beta_mode         = beta_reg;
  assign port_beta_tx_en        = beta_tx_reg;
  assign irq                    = irq_reg;
  assign link_control_lines_out = ctl_out_reg;
  assign link_control_lines_oe  = ctl_oe_reg;
  assign link_data_lines_out    = d_out_reg;
  assign link_data_lines_oe     = d_oe_reg;
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_beta_protocol: assert property (aresetn && link_protocol_select |=> link_beta_mode) // [R1]
    else $error("beta protocol not selected");
  a_legacy_protocol: assert property (!link_protocol_select |=> !link_beta_mode) // [R2]
    else $error("legacy protocol not selected");
  a_cable_inactive: assert property ((port_bias_detect == '0) |=> cable_inactive_flag) // [R4]
    else $error("cable inactive not flagged");
  a_cable_active: assert property ((port_bias_detect != '0) |=> !cable_inactive_flag) // [R5]
    else $error("cable active not flagged");
  a_power_lost_irq: assert property ( // [R6]
    $fell(cable_power_sense) && int_mask_reg[phy_link_pkg::INT_POWER_LOST] |=> ##1 irq)
    else $error("power loss interrupt missing");
  a_link_release: assert property (!drive_en |=> link_data_lines_oe == '0 // [R9]
    && link_control_lines_oe == '0)
    else $error("link lines driven while released");
  a_link_value: assert property ($rose(d_oe_reg[0]) |-> link_data_lines_out // [R9]
    == $past(link_out_reg[LW-1:0]))
    else $error("link data wrong while driving");
  a_legacy_no_beta: assert property ( // [R10]
    strap_bus.legacy_only != '0 |-> (port_beta_tx_en & strap_bus.legacy_only) == '0)
    else $error("beta signalling on legacy port");
  a_write_answer: assert property (wr_commit |=> s_axi_bvalid)
    else $error("write response missing");
  c_power_lost: cover property ($fell(cable_power_sense) ##2 irq);
  c_cable_up: cover property ($fell(cable_inactive_flag));
  c_beta_port: cover property (port_beta_tx_en[0]);
  c_unmapped_read: cover property (s_axi_rvalid && s_axi_rresp == phy_link_pkg::RESP_SLVERR);
endmodule

// File: src/phy_link_pkg.sv
package phy_link_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W      = 8;
  localparam int DATA_W      = 32;
  localparam int STRB_W      = 4;
  localparam int NUM_PORTS   = 3;
  localparam int NUM_STRAPS  = 2;
  localparam int LINK_D_W    = 8;
  localparam int LINK_C_W    = 2;
  localparam int CTRL_W      = 3;
  localparam int INT_W       = 3;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CTRL_OFF       = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFF     = 8'h04;
  localparam logic [ADDR_W-1:0] INT_STATUS_OFF = 8'h08;
  localparam logic [ADDR_W-1:0] INT_MASK_OFF   = 8'h0c;
  localparam logic [ADDR_W-1:0] LINK_OUT_OFF   = 8'h10;
  localparam logic [ADDR_W-1:0] LINK_IN_OFF    = 8'h14;

  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  localparam int CTRL_BETA_LSB = 0;
  localparam int CTRL_DRIVE    = 2;
  localparam int ST_CNA        = 0;
  localparam int ST_CPS        = 1;
  localparam int ST_BETA       = 2;
  localparam int ST_LEGACY_LSB = 3;
  localparam int ST_BIAS_LSB   = 8;
  localparam int INT_POWER_LOST = 0;
  localparam int INT_CABLE_DOWN = 1;
  localparam int INT_CABLE_UP   = 2;
  localparam int LINK_CTL_LSB   = 8;
  localparam int BYTE_W         = 8;

  // ----------------------------------------------------------------
  // reset values and responses
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] WORD_ZERO   = 32'h0000_0000;
  localparam logic [1:0]        RESP_OKAY   = 2'h0;
  localparam logic [1:0]        RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    STRAP_WAIT    = 2'b00,
    STRAP_CAPTURE = 2'b01,
    STRAP_HOLD    = 2'b11
  } strap_state_t;

endpackage

// File: src/strap_if.sv
`timescale 1ns/1ps
interface strap_if;
  logic [phy_link_pkg::NUM_STRAPS-1:0] legacy_only;
  logic                                captured;
  modport capture (output legacy_only, output captured);
  modport user    (input legacy_only, input captured);
endinterface

// File: src/strap_capture.sv
`timescale 1ns/1ps
module strap_capture (
  // clock and reset
  input wire logic                                aclk,
  input wire logic                                aresetn,
  // strap pins
  input wire logic [phy_link_pkg::NUM_STRAPS-1:0] strap_in,
  // latched modes
  strap_if.capture                                modes
);

  phy_link_pkg::strap_state_t          state_reg;
  logic [phy_link_pkg::NUM_STRAPS-1:0] legacy_reg;
  logic                                captured_reg;

  // ----------------------------------------------------------------
  // capture sequence
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= phy_link_pkg::STRAP_WAIT;
    end else begin
      case (state_reg)
        phy_link_pkg::STRAP_WAIT:    state_reg <= phy_link_pkg::STRAP_CAPTURE;
        phy_link_pkg::STRAP_CAPTURE: state_reg <= phy_link_pkg::STRAP_HOLD;
        phy_link_pkg::STRAP_HOLD:    state_reg <= phy_link_pkg::STRAP_HOLD;
        default:                     state_reg <= phy_link_pkg::STRAP_WAIT;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      legacy_reg   <= '0;
      captured_reg <= 1'b0;
    end else if (state_reg == phy_link_pkg::STRAP_CAPTURE) begin
      legacy_reg   <= strap_in; // [R7] [R8] [R11]
      captured_reg <= 1'b1;
    end
  end

  assign modes.legacy_only = legacy_reg;
  assign modes.captured    = captured_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_port0_strap_sample: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
    (state_reg == phy_link_pkg::STRAP_CAPTURE) |=> legacy_reg[0] == $past(strap_in[0]))
    else $error("port 0 strap not sampled");
  a_port1_strap_sample: assert property (@(posedge aclk) disable iff (!aresetn) // [R8]
    (state_reg == phy_link_pkg::STRAP_CAPTURE) |=> legacy_reg[1] == $past(strap_in[1]))
    else $error("port 1 strap not sampled");
  a_modes_held: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
    captured_reg |=> $stable(legacy_reg) && captured_reg)
    else $error("strap modes changed after capture");
  a_capture_bound: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
    aresetn && !captured_reg |-> ##[1:2] captured_reg)
    else $error("strap capture late");
  c_legacy_port: cover property (@(posedge aclk) disable iff (!aresetn)
    captured_reg && legacy_reg[0]);

endmodule

// File: tb/link_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// far-side controller on the two-way link lines
// ----------------------------------------------------------------
module link_model (
  // clock
  input  wire logic       aclk,
  // device drive
  input  wire logic [9:0] dev_out,
  input  wire logic [9:0] dev_oe,
  // controller drive
  input  wire logic [9:0] far_out,
  input  wire logic [9:0] far_oe,
  // resolved lines
  output logic      [9:0] lines
);
  logic [9:0] hold_reg = 10'h000;

  // holders keep the last level of released lines
  always @(posedge aclk) begin
    hold_reg <= lines;
  end

  always_comb begin
    for (int i = 0; i < 10; i++) begin
      lines[i] = dev_oe[i] ? dev_out[i] : (far_oe[i] ? far_out[i] : hold_reg[i]);
    end
  end
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, port_beta_tx_en, ctl_out, ctl_oe;
  logic        link_protocol_select = 1'b1, cable_power_sense = 1'b1;
  logic        port0_legacy_only_strap = 1'b1, port1_legacy_only_strap = 1'b0;
  logic [2:0]  port_bias_detect = 3'h0;
  logic [7:0]  dat_out, dat_oe;
  logic [9:0]  lines, far_out = 10'h000, far_oe = 10'h000;
  logic        cable_inactive_flag, link_beta_mode, irq;
  logic [31:0] d;
  logic [1:0]  r;
  int          errors = 0, checked = 0, cycles = 0;

  always #2.5 aclk = ~aclk;

  phy_link_status u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .link_protocol_select, .port0_legacy_only_strap, .port1_legacy_only_strap,
    .port_bias_detect, .cable_power_sense, .link_control_lines_in(lines[9:8]),
    .link_control_lines_out(ctl_out), .link_control_lines_oe(ctl_oe),
    .link_data_lines_in(lines[7:0]), .link_data_lines_out(dat_out),
    .link_data_lines_oe(dat_oe), .cable_inactive_flag, .link_beta_mode,
    .port_beta_tx_en, .irq);

  link_model u_far (.aclk, .dev_out({ctl_out, dat_out}), .dev_oe({ctl_oe, dat_oe}),
    .far_out, .far_oe, .lines);

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    bit aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready === 1'b1) begin aw_done = 1; s_axi_awvalid <= 1'b0; end
      if (!w_done && s_axi_wready === 1'b1) begin w_done = 1; s_axi_wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a, d, r);
    check({30'h0, r}, {30'h0, phy_link_pkg::RESP_OKAY});
    check(d, exp);
  endtask

  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      finish_test();
    end
  end

  initial begin
    // straps and reset values
    do_reset();
    check({31'h0, link_beta_mode}, 32'h0000_0001);
    rdchk(phy_link_pkg::STATUS_OFF, 32'h0000_000f);
    rdchk(phy_link_pkg::CTRL_OFF, 32'h0000_0000);
    port0_legacy_only_strap <= 1'b0;
    port1_legacy_only_strap <= 1'b1;
    rdchk(phy_link_pkg::STATUS_OFF, 32'h0000_000f);
    $display("test straps done");
    // link lines both ways
    wr(phy_link_pkg::LINK_OUT_OFF, 32'h0000_02a5, r);
    check({30'h0, r}, {30'h0, phy_link_pkg::RESP_OKAY});
    wr(phy_link_pkg::CTRL_OFF, 32'h0000_0007, r);
    repeat (3) @(posedge aclk);
    check({22'h0, lines}, 32'h0000_02a5);
    check({30'h0, port_beta_tx_en}, 32'h0000_0002);
    rdchk(phy_link_pkg::LINK_IN_OFF, 32'h0000_02a5);
    wr(phy_link_pkg::CTRL_OFF, 32'h0000_0003, r);
    repeat (3) @(posedge aclk);
    check({22'h0, ctl_oe, dat_oe}, 32'h0000_0000);
    check({22'h0, lines}, 32'h0000_02a5);
    far_out <= 10'h15a;
    far_oe <= 10'h3ff;
    rdchk(phy_link_pkg::LINK_IN_OFF, 32'h0000_015a);
    far_oe <= 10'h000;
    repeat (3) @(posedge aclk);
    check({22'h0, lines}, 32'h0000_015a);
    $display("test link lines done");
    // cable events and interrupt
    wr(phy_link_pkg::INT_MASK_OFF, 32'h0000_0001, r);
    wr(phy_link_pkg::INT_STATUS_OFF, 32'h0000_0007, r);
    cable_power_sense <= 1'b0;
    repeat (3) @(posedge aclk);
    check({31'h0, irq}, 32'h0000_0001);
    rdchk(phy_link_pkg::INT_STATUS_OFF, 32'h0000_0001);
    wr(phy_link_pkg::INT_STATUS_OFF, 32'h0000_0001, r);
    repeat (3) @(posedge aclk);
    check({31'h0, irq}, 32'h0000_0000);
    port_bias_detect <= 3'h4;
    repeat (3) @(posedge aclk);
    check({31'h0, cable_inactive_flag}, 32'h0000_0000);
    port_bias_detect <= 3'h0;
    repeat (3) @(posedge aclk);
    check({31'h0, cable_inactive_flag}, 32'h0000_0001);
    check({31'h0, irq}, 32'h0000_0000);
    rdchk(phy_link_pkg::INT_STATUS_OFF, 32'h0000_0006);
    cable_power_sense <= 1'b1;
    $display("test events done");
    // unmapped place
    rd(8'h40, d, r);
    check({30'h0, r}, {30'h0, phy_link_pkg::RESP_SLVERR});
    check(d, 32'h0000_0000);
    wr(8'h40, 32'h0000_ffff, r);
    check({30'h0, r}, {30'h0, phy_link_pkg::RESP_SLVERR});
    $display("test unmapped done");
    // second reset, legacy protocol, held fixed while running
    aresetn <= 1'b0;
    link_protocol_select <= 1'b0;
    do_reset();
    check({31'h0, link_beta_mode}, 32'h0000_0000);
    rdchk(phy_link_pkg::STATUS_OFF, 32'h0000_0013);
    wr(phy_link_pkg::CTRL_OFF, 32'h0000_0003, r);
    repeat (3) @(posedge aclk);
    check({30'h0, port_beta_tx_en}, 32'h0000_0001);
    $display("test second reset done");
    finish_test();
  end
endmodule
